// file: hdl/dbs_sizing.sv
// local memory access sequencer with dynamic 16/32-bit bus sizing
`timescale 1ns/1ps
module dbs_sizing #(
    parameter int RCA_W = dbs_pkg::RCA_W_DEF
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [dbs_pkg::DATA_W-1:0] req_addr,
    input wire logic [dbs_pkg::STAT_W-1:0] req_status,
    input wire logic req_write,
    input wire logic req_rmw,
    input wire logic req_locked,
    input wire logic [dbs_pkg::DATA_W-1:0] req_wdata,
    input wire logic [dbs_pkg::DATA_W-1:0] req_field_mask,
    input wire logic [dbs_pkg::CAS_W-1:0] req_cas_n,
    input wire logic preempt,
    output logic resp_valid,
    output logic [dbs_pkg::DATA_W-1:0] resp_rdata,
    input wire logic local_clock_phase2,
    input wire logic half_width_n,
    input wire logic local_ready,
    input wire logic bus_fault_in,
    input wire logic page_mode_ack_n,
    input wire logic [dbs_pkg::DATA_W-1:0] muxed_addr_data_bus_in,
    output logic [dbs_pkg::DATA_W-1:0] muxed_addr_data_bus_out,
    output logic muxed_addr_data_bus_oe,
    output logic [RCA_W-1:0] row_column_addr_bus,
    output logic row_strobe_n,
    output logic [dbs_pkg::CAS_W-1:0] column_strobe_n,
    output logic write_en_n
);
    import dbs_pkg::*;

    dbs_lane_if lane_c ();

    dbs_lane_swap u_lane (
        .core_clk(core_clk),
        .rst(rst),
        .lane(lane_c)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage feeds only the second
    logic [3:0] ctl_s1_r;
    logic [3:0] ctl_s2_r;
    logic [DATA_W-1:0] bus_s1_r;
    logic [DATA_W-1:0] bus_s2_r;
    logic p2_s1_r;
    logic p2_s2_r;
    logic p2_d_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctl_s1_r <= 4'h0;
            ctl_s2_r <= 4'h0;
            bus_s1_r <= DATA_RST;
            bus_s2_r <= DATA_RST;
            p2_s1_r <= 1'b0;
            p2_s2_r <= 1'b0;
            p2_d_r <= 1'b0;
        end else begin
            ctl_s1_r <= {half_width_n, local_ready, bus_fault_in, page_mode_ack_n};
            ctl_s2_r <= ctl_s1_r;
            bus_s1_r <= muxed_addr_data_bus_in;
            bus_s2_r <= bus_s1_r;
            p2_s1_r <= local_clock_phase2;
            p2_s2_r <= p2_s1_r;
            p2_d_r <= p2_s2_r;
        end
    end

    logic tick;
    logic s_hw;
    logic s_rdy;
    logic s_flt;
    logic s_pg;
    assign tick = p2_s2_r & ~p2_d_r;
    assign s_hw = ctl_s2_r[3];
    assign s_rdy = ctl_s2_r[2];
    assign s_flt = ctl_s2_r[1];
    assign s_pg = ctl_s2_r[0];

    ////////////////////////////////////////////////////////////////////////
    // sequencing state
    dbs_state_t state_r;
    logic sel_r;
    logic wide16_r;
    logic wr_phase_r;
    logic rmw_r;
    logic locked_r;
    logic page_r;
    logic nosamp_r;
    logic [DATA_W-1:0] addr_r;
    logic [STAT_W-1:0] stat_r;
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W-1:0] mask_r;
    logic [CAS_W-1:0] cas_r;

    logic in_data;
    logic skip;
    logic acc_done;
    logic is16_now;
    logic unit_last;
    logic go_write;
    logic page_nxt;
    assign in_data = (state_r == ST_DATA) && tick;
    // paged 32-bit sequence: ready, fault and half-width are no longer looked at
    assign skip = nosamp_r;
    assign acc_done = in_data && (skip || (s_rdy && !s_flt));
    // locked cycles never treat memory as 16-bit
    assign is16_now = !locked_r && (wide16_r || (!nosamp_r && !s_hw));
    assign unit_last = sel_r || !is16_now;
    assign go_write = unit_last && !wr_phase_r && rmw_r;
    assign page_nxt = page_r || !s_pg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            sel_r <= SEL_FIRST;
            wide16_r <= 1'b0;
            wr_phase_r <= 1'b0;
            rmw_r <= 1'b0;
            locked_r <= 1'b0;
            page_r <= 1'b0;
            nosamp_r <= 1'b0;
            addr_r <= DATA_RST;
            stat_r <= '0;
            wdata_r <= DATA_RST;
            mask_r <= DATA_RST;
            cas_r <= CAS_IDLE_N;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (req_valid) begin
                        state_r <= ST_ADDR;
                        sel_r <= SEL_FIRST;
                        wide16_r <= 1'b0;
                        page_r <= 1'b0;
                        nosamp_r <= 1'b0;
                        wr_phase_r <= req_write && !req_rmw;
                        rmw_r <= req_rmw;
                        locked_r <= req_locked;
                        addr_r <= req_addr;
                        stat_r <= req_status;
                        wdata_r <= req_wdata;
                        mask_r <= req_field_mask;
                        cas_r <= req_cas_n;
                    end
                end
                ST_ADDR: begin
                    if (tick) begin
                        state_r <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (in_data && !skip && s_flt) begin
                        // fault: redo the aborted access as a standard cycle
                        state_r <= ST_ADDR;
                        page_r <= 1'b0;
                    end else if (acc_done) begin
                        page_r <= page_nxt;
                        if (!page_r && !s_pg && s_hw && !sel_r && !wide16_r) begin
                            nosamp_r <= 1'b1;
                        end
                        if (!sel_r && !wide16_r) begin
                            wide16_r <= is16_now;
                        end
                        if (!unit_last) begin
                            sel_r <= SEL_SECOND;
                            state_r <= page_nxt ? ST_DATA : ST_ADDR;
                        end else if (go_write) begin
                            wr_phase_r <= 1'b1;
                            sel_r <= SEL_FIRST;
                            if (preempt) begin
                                state_r <= ST_PARK;
                            end else begin
                                state_r <= page_nxt ? ST_DATA : ST_ADDR;
                            end
                        end else begin
                            state_r <= ST_DONE;
                        end
                    end
                end
                ST_PARK: begin
                    if (!preempt) begin
                        state_r <= ST_ADDR;
                        page_r <= 1'b0;
                        if (locked_r) begin
                            wr_phase_r <= 1'b0;
                        end
                    end
                end
                ST_DONE: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // datapath hookup; field insert uses the merged read word
    always_comb begin
        lane_c.sel = sel_r;
        lane_c.cas_n_in = cas_r;
        lane_c.wdata_in = rmw_r ? ((lane_c.merged & ~mask_r) | (wdata_r & mask_r)) : wdata_r;
        lane_c.bus_in = bus_s2_r;
        lane_c.latch_first = acc_done && !wr_phase_r && !sel_r;
        lane_c.latch_second = acc_done && !wr_phase_r && sel_r;
        lane_c.half_hi = s_hw;
        lane_c.clear = (state_r == ST_IDLE) && req_valid;
    end

    ////////////////////////////////////////////////////////////////////////
    // pin and response registers, one cycle behind the state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            muxed_addr_data_bus_out <= DATA_RST;
            muxed_addr_data_bus_oe <= 1'b0;
            row_column_addr_bus <= '0;
            row_strobe_n <= 1'b1;
            column_strobe_n <= CAS_IDLE_N;
            write_en_n <= 1'b1;
        end else begin
            muxed_addr_data_bus_oe <= (state_r == ST_ADDR) ||
                                      ((state_r == ST_DATA) && wr_phase_r);
            row_strobe_n <= !((state_r == ST_ADDR) || (state_r == ST_DATA));
            write_en_n <= !((state_r == ST_DATA) && wr_phase_r);
            row_column_addr_bus <= {addr_r[SEL_BIT+1 +: RCA_W-1], sel_r};
            if (state_r == ST_ADDR) begin
                muxed_addr_data_bus_out <= {addr_r[DATA_W-1:SEL_BIT+1], sel_r, stat_r};
            end else begin
                muxed_addr_data_bus_out <= lane_c.wdata_out;
            end
            if (state_r != ST_DATA) begin
                column_strobe_n <= CAS_IDLE_N;
            end else if (!wr_phase_r) begin
                column_strobe_n <= CAS_ALL_N;
            end else begin
                column_strobe_n <= lane_c.cas_n_out;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_ready <= 1'b0;
            resp_valid <= 1'b0;
            resp_rdata <= DATA_RST;
        end else begin
            req_ready <= (state_r == ST_IDLE) && !req_valid;
            resp_valid <= (state_r == ST_DONE);
            if (state_r == ST_DONE) begin
                resp_rdata <= lane_c.merged;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    first_sel_zero_a: assert property (
        (state_r == ST_IDLE) && req_valid |=> (sel_r == SEL_FIRST) && (state_r == ST_ADDR)
    ) else $error("new location did not start with select 0");

    sel_on_bus_a: assert property (
        (state_r == ST_ADDR) |=> muxed_addr_data_bus_oe &&
            (muxed_addr_data_bus_out[SEL_BIT] == $past(sel_r))
    ) else $error("select bit missing from muxed bus bit 4");

    sel_on_rca_a: assert property (
        (state_r == ST_DATA) |=> (row_column_addr_bus[0] == $past(sel_r))
    ) else $error("select bit missing from row-column bit 0");

    no_second_access_a: assert property (
        acc_done && !sel_r && !wide16_r && s_hw |=> (sel_r == SEL_FIRST)
    ) else $error("second access made after a 32-bit answer");

    second_access_a: assert property (
        acc_done && !sel_r && !wide16_r && !s_hw && !nosamp_r && !locked_r
            |=> (sel_r == SEL_SECOND) && (state_r inside {ST_ADDR, ST_DATA})
    ) else $error("16-bit answer not followed by select-1 access");

    strobe_swap_a: assert property (
        (state_r == ST_DATA) && wr_phase_r && sel_r
            |=> (column_strobe_n == {$past(cas_r[1:0]), $past(cas_r[3:2])})
    ) else $error("strobes not exchanged on select-1 write");

    read_strobes_a: assert property (
        (state_r == ST_DATA) && !wr_phase_r |=> (column_strobe_n == CAS_ALL_N)
    ) else $error("read cycle with a strobe inactive");

    reads_before_writes_a: assert property (
        $rose(wr_phase_r) && rmw_r |-> (sel_r == SEL_FIRST) && ($past(sel_r) == wide16_r)
    ) else $error("write began before both reads finished");

    locked_sel_zero_a: assert property (
        locked_r && (state_r != ST_IDLE) |-> (sel_r == SEL_FIRST) && !wide16_r
    ) else $error("locked operation used select 1");

    page_goes_data_a: assert property (
        acc_done && !unit_last && page_nxt |=> (state_r == ST_DATA)
    ) else $error("paged second half inserted an address state");

    locked_restart_a: assert property (
        (state_r == ST_PARK) && locked_r && !preempt |=> !wr_phase_r && (state_r == ST_ADDR)
    ) else $error("locked cycle not restarted from the read");

endmodule : dbs_sizing

// file: hdl/dbs_pkg.sv
// constants and types shared by the dynamic bus sizing logic
package dbs_pkg;

    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int CAS_W = 4;
    localparam int STAT_W = 4;
    localparam int SEL_BIT = 4;
    localparam int RCA_W_DEF = 10;
    localparam int SYNC_STAGES = 2;

    localparam logic [CAS_W-1:0] CAS_IDLE_N = 4'hf;
    localparam logic [CAS_W-1:0] CAS_ALL_N = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic SEL_FIRST = 1'b0;
    localparam logic SEL_SECOND = 1'b1;

    // standard cycle = address state + data state, page cycle = data state only
    localparam int STD_STATES = 2;
    localparam int PAGE_STATES = 1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_PARK,
        ST_DONE
    } dbs_state_t;

endpackage : dbs_pkg

// file: hdl/dbs_lane_if.sv
// carrier between the sequencer and the lane swap / read merge datapath
`timescale 1ns/1ps
interface dbs_lane_if;
    import dbs_pkg::*;
    logic sel;
    logic [CAS_W-1:0] cas_n_in;
    logic [CAS_W-1:0] cas_n_out;
    logic [DATA_W-1:0] wdata_in;
    logic [DATA_W-1:0] wdata_out;
    logic [DATA_W-1:0] bus_in;
    logic latch_first;
    logic latch_second;
    logic half_hi;
    logic clear;
    logic [DATA_W-1:0] merged;

    modport ctrl (
        output sel, cas_n_in, wdata_in, bus_in, latch_first, latch_second, half_hi, clear,
        input cas_n_out, wdata_out, merged
    );
    modport lane (
        input sel, cas_n_in, wdata_in, bus_in, latch_first, latch_second, half_hi, clear,
        output cas_n_out, wdata_out, merged
    );
endinterface : dbs_lane_if

// file: hdl/dbs_lane_swap.sv
// strobe and data half swapping plus the 16-bit read merge register
`timescale 1ns/1ps
module dbs_lane_swap (
    input wire logic core_clk,
    input wire logic rst,
    dbs_lane_if.lane lane
);
    import dbs_pkg::*;

    logic [DATA_W-1:0] merge_r;

    ////////////////////////////////////////////////////////////////////////
    // second access exchanges strobe pairs and bus halves
    always_comb begin
        if (lane.sel) begin
            lane.cas_n_out = {lane.cas_n_in[1:0], lane.cas_n_in[3:2]};
            lane.wdata_out = {lane.wdata_in[HALF_W-1:0],
                              lane.wdata_in[DATA_W-1:HALF_W]};
        end else begin
            lane.cas_n_out = lane.cas_n_in;
            lane.wdata_out = lane.wdata_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // first cycle keeps all 32 bits, second copies the live half into the other half only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            merge_r <= DATA_RST;
        end else if (lane.clear) begin
            merge_r <= DATA_RST;
        end else if (lane.latch_first) begin
            merge_r <= lane.bus_in;
        end else if (lane.latch_second) begin
            if (lane.half_hi) begin
                merge_r[HALF_W-1:0] <= lane.bus_in[DATA_W-1:HALF_W];
            end else begin
                merge_r[DATA_W-1:HALF_W] <= lane.bus_in[HALF_W-1:0];
            end
        end
    end

    assign lane.merged = merge_r;

endmodule : dbs_lane_swap

// file: dv/dbs_mem_model.sv
// behavioural local memory and decode logic seen by the sizing sequencer
`timescale 1ns/1ps
module dbs_mem_model (
    input wire logic [1:0] mode,
    input wire logic page_en,
    input wire logic [31:0] word,
    input wire logic sel,
    input wire logic [3:0] column_strobe_n,
    input wire logic write_en_n,
    output logic local_clock_phase2,
    output logic half_width_n,
    output logic local_ready,
    output logic bus_fault_in,
    output logic page_mode_ack_n,
    output logic [31:0] bus_in
);
    // mode 0 = 32-bit memory, 1 = 16-bit on low half, 2 = 16-bit on high half
    logic [31:0] val;
    logic [31:0] held = 32'h0000_0000;
    logic rd;

    ////////////////////////////////////////////////////////////////////////////
    // local clock runs free, four core clocks per phase
    initial begin
        local_clock_phase2 = 1'b0;
        forever #40 local_clock_phase2 = ~local_clock_phase2;
    end

    assign local_ready = 1'b1;
    assign bus_fault_in = 1'b0;
    assign page_mode_ack_n = ~page_en;
    // low half always answers low, high half copies the select bit
    assign half_width_n = (mode == 2'd0) ? 1'b1 : (mode == 2'd1) ? 1'b0 : sel;

    ////////////////////////////////////////////////////////////////////////////
    // high half memory gives its upper word first, as if the select bit were inverted
    always_comb begin
        case (mode)
            2'd1: val = sel ? {~word[31:16], word[31:16]} : {~word[15:0], word[15:0]};
            2'd2: val = sel ? {word[15:0], ~word[15:0]} : {word[31:16], ~word[31:16]};
            default: val = word;
        endcase
    end

    // a released bus shows the inverse of what was last driven, never a stale match
    assign rd = (column_strobe_n != 4'hf) && write_en_n;
    always @(val or rd) begin
        if (rd)
            held = val;
    end
    assign bus_in = rd ? val : ~held;
endmodule : dbs_mem_model

// file: dv/dynamic_bus_sizing_tb_top.sv
// self-checking bench for the dynamic bus sizing sequencer
`timescale 1ns/1ps
`define CHK(g, e) chk(38'(g), 38'(e))
module dynamic_bus_sizing_tb_top;
    import dbs_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0, req_write = 1'b0, req_rmw = 1'b0, req_locked = 1'b0;
    logic preempt = 1'b0, page_en = 1'b0;
    logic [1:0] mode = 2'd0;
    logic [31:0] word = 32'h0000_0000, req_wdata = 32'h0000_0000, req_field_mask = 32'h0;
    logic [3:0] req_cas_n = 4'hf;
    logic req_ready, resp_valid, row_strobe_n, write_en_n, muxed_addr_data_bus_oe;
    logic local_clock_phase2, half_width_n, local_ready, bus_fault_in, page_mode_ack_n;
    logic [31:0] resp_rdata, muxed_addr_data_bus_in, muxed_addr_data_bus_out;
    logic [9:0] row_column_addr_bus;
    logic [3:0] column_strobe_n;
    int mismatches = 0;
    int n_checks = 0;
    logic [37:0] log_q[$];
    logic [37:0] prev_e = '0;
    logic first_addr = 1'b0;
    wire [37:0] cur_e = {~write_en_n, row_column_addr_bus[0], column_strobe_n,
                         muxed_addr_data_bus_out};

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    dbs_sizing i_dbs_sizing (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_addr(32'h0000_1240), .req_status(4'h3),
        .req_write(req_write), .req_rmw(req_rmw), .req_locked(req_locked),
        .req_wdata(req_wdata), .req_field_mask(req_field_mask), .req_cas_n(req_cas_n),
        .preempt(preempt), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .local_clock_phase2(local_clock_phase2), .half_width_n(half_width_n),
        .local_ready(local_ready), .bus_fault_in(bus_fault_in),
        .page_mode_ack_n(page_mode_ack_n), .muxed_addr_data_bus_in(muxed_addr_data_bus_in),
        .muxed_addr_data_bus_out(muxed_addr_data_bus_out),
        .muxed_addr_data_bus_oe(muxed_addr_data_bus_oe),
        .row_column_addr_bus(row_column_addr_bus), .row_strobe_n(row_strobe_n),
        .column_strobe_n(column_strobe_n), .write_en_n(write_en_n));

    dbs_mem_model i_dbs_mem_model (.mode(mode), .page_en(page_en), .word(word),
        .sel(row_column_addr_bus[0]), .column_strobe_n(column_strobe_n),
        .write_en_n(write_en_n), .local_clock_phase2(local_clock_phase2),
        .half_width_n(half_width_n), .local_ready(local_ready), .bus_fault_in(bus_fault_in),
        .page_mode_ack_n(page_mode_ack_n), .bus_in(muxed_addr_data_bus_in));

    task automatic chk(input logic [37:0] g, input logic [37:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    ////////////////////////////////////////////////////////////////////////////
    // access log: one entry per strobed access, {write, select, strobes, bus out}
    always @(negedge core_clk) begin
        if (column_strobe_n != CAS_IDLE_N &&
            (prev_e[35:32] == CAS_IDLE_N || prev_e[37:36] != cur_e[37:36]))
            log_q.push_back(cur_e);
        if (first_addr && !row_strobe_n) begin
            `CHK(muxed_addr_data_bus_oe, 1'b1);
            `CHK(muxed_addr_data_bus_out[SEL_BIT], SEL_FIRST);
            first_addr = 1'b0;
        end
        prev_e = cur_e;
    end

    // one whole operation; preempt, if asked, is dropped well after the read unit ends
    task automatic op(input logic w, m, l, p, input logic [31:0] wd, mk, input logic [3:0] cs);
        int k;
        @(negedge core_clk);
        `CHK(req_ready, 1'b1);
        log_q.delete();
        first_addr = 1'b1;
        {req_write, req_rmw, req_locked, preempt} = {w, m, l, p};
        req_wdata = wd;
        req_field_mask = mk;
        req_cas_n = cs;
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
            if (k == 100)
                preempt = 1'b0;
        end while (resp_valid !== 1'b1 && k < 3000);
        `CHK(k < 3000, 1'b1);
    endtask : op

    // access kinds packed two bits each: 00 read s0, 01 read s1, 10 write s0, 11 write s1
    task automatic chk_seq(input int n, input logic [15:0] exp);
        logic [15:0] got;
        got = '0;
        foreach (log_q[i]) got = {got[13:0], log_q[i][37:36]};
        `CHK(log_q.size(), n);
        `CHK(got, exp);
    endtask : chk_seq

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_read32();
        mode = 2'd0;
        word = 32'h1234_5678;
        op(1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 32'h0, 4'h0);
        chk_seq(1, 16'h0000);
        `CHK(resp_rdata, word);
        `CHK(log_q[0][35:32], CAS_ALL_N);
        $display("test read32 finished");
    endtask : t_read32

    task automatic t_read16_lo();
        mode = 2'd1;
        page_en = 1'b0;
        word = 32'hcafe_0123;
        op(1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 32'h0, 4'h0);
        chk_seq(2, 16'h0001);
        `CHK(resp_rdata, word);
        `CHK({log_q[0][35:32], log_q[1][35:32]}, 8'h00);
        $display("test read16_lo finished");
    endtask : t_read16_lo

    task automatic t_read16_hi();
        mode = 2'd2;
        page_en = 1'b1;
        word = 32'h89ab_4d5e;
        op(1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 32'h0, 4'h0);
        chk_seq(2, 16'h0001);
        `CHK(resp_rdata, word);
        `CHK({log_q[0][35:32], log_q[1][35:32]}, 8'h00);
        $display("test read16_hi finished");
    endtask : t_read16_hi

    task automatic t_write16();
        logic [31:0] wd;
        wd = 32'ha5c3_1e2f;
        mode = 2'd2;
        page_en = 1'b1;
        op(1'b1, 1'b0, 1'b0, 1'b0, wd, 32'h0, 4'hc);
        chk_seq(2, 16'h000b);
        `CHK(log_q[0][35:0], {4'hc, wd});
        `CHK(log_q[1][35:0], {4'h3, wd[15:0], wd[31:16]});
        $display("test write16 finished");
    endtask : t_write16

    // field sits in the first half only, both halves must still be read and written
    task automatic t_rmw16();
        logic [31:0] ex;
        mode = 2'd1;
        page_en = 1'b1;
        word = 32'h1357_9bdf;
        ex = (word & ~32'h0000_0ff0) | (32'h0000_0aa0 & 32'h0000_0ff0);
        op(1'b0, 1'b1, 1'b0, 1'b0, 32'h0000_0aa0, 32'h0000_0ff0, 4'h0);
        chk_seq(4, 16'h001b);
        `CHK(log_q[2][31:0], ex);
        `CHK(log_q[3][31:0], {ex[15:0], ex[31:16]});
        $display("test rmw16 finished");
    endtask : t_rmw16

    // unlocked insert on paged 32-bit memory; once pre-empted it resumes at the write
    task automatic t_rmw32_resume();
        mode = 2'd0;
        page_en = 1'b1;
        word = 32'h2468_ace0;
        op(1'b0, 1'b1, 1'b0, 1'b1, 32'h5a00_0000, 32'hff00_0000, 4'h0);
        chk_seq(2, 16'h0002);
        `CHK(log_q[1][31:0], 32'h5a68_ace0);
        $display("test rmw32_resume finished");
    endtask : t_rmw32_resume

    task automatic t_locked();
        mode = 2'd1;
        page_en = 1'b0;
        op(1'b0, 1'b1, 1'b1, 1'b0, 32'h0000_00f0, 32'h0000_00f0, 4'h0);
        chk_seq(2, 16'h0002);
        $display("test locked finished");
    endtask : t_locked

    task automatic t_locked_preempt();
        mode = 2'd0;
        word = 32'h0f0f_3c3c;
        op(1'b0, 1'b1, 1'b1, 1'b1, 32'h0000_0001, 32'h0000_0001, 4'h0);
        chk_seq(3, 16'h0002);
        `CHK(log_q[2][31:0], 32'h0f0f_3c3d);
        $display("test locked_preempt finished");
    endtask : t_locked_preempt

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    // all operations finish in a few hundred cycles
    initial begin
        #100000;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        t_read32();
        t_read16_lo();
        t_read16_hi();
        t_write16();
        t_rmw16();
        t_rmw32_resume();
        t_locked();
        t_locked_preempt();
        end_sim();
    end
endmodule : dynamic_bus_sizing_tb_top
